// [hw/amsc_pkg.sv]
// Purpose: shared constants and types for the adc mode sequencer link
// Assumes: single 50 MHz system clock on both ends
// Notes:   device register indices travel over the link as 4-bit codes
package amsc_pkg;
  // widths and depths
  localparam int DATA_W    = 12;               // conversion result width
  localparam int BUF_DEPTH = 16;               // data buffer entries
  localparam int SCL_W     = 10;               // scl timing fields, in clocks
  // device register indices
  localparam logic [3:0] REG_MODE    = 4'h0;   // operating_mode_select
  localparam logic [3:0] REG_SCAN    = 4'h1;   // scan_channel_enable
  localparam logic [3:0] REG_GO      = 4'h2;   // sequence_go_bit in bit 0
  localparam logic [3:0] REG_STOP    = 4'h3;   // sequence_stop_bit in bit 0
  localparam logic [3:0] REG_POLICY  = 4'h4;   // buffer_fill_policy
  localparam logic [3:0] REG_DIV     = 4'h5;   // conversion_cycle_divider
  localparam logic [3:0] REG_ACHEN   = 4'h6;   // alert_channel_enable
  localparam logic [3:0] REG_ACTL    = 4'h7;   // window_compare_enable in bit 0
  localparam logic [3:0] REG_HI_TH   = 4'h8;   // high threshold, result bits 11:4
  localparam logic [3:0] REG_LO_TH   = 4'h9;   // low threshold, result bits 11:4
  localparam logic [3:0] REG_HI_FLAG = 4'hA;   // latched high flags
  localparam logic [3:0] REG_LO_FLAG = 4'hB;   // latched low flags
  localparam logic [3:0] REG_STATUS  = 4'hC;   // {fill count, state}
  // mode and policy encodings
  localparam logic [2:0] MODE_CH0_A  = 3'b000;
  localparam logic [2:0] MODE_CH0_B  = 3'b001;
  localparam logic [2:0] MODE_SEQ_A  = 3'b100;
  localparam logic [2:0] MODE_SEQ_B  = 3'b101;
  localparam logic [2:0] MODE_AUTO   = 3'b110;
  localparam logic [2:0] POL_STOP_BURST  = 3'b000;
  localparam logic [2:0] POL_START_BURST = 3'b001;
  localparam logic [2:0] POL_PRE_ALERT   = 3'b100;
  localparam logic [2:0] POL_POST_ALERT  = 3'b110;
  localparam logic [7:0] FLAG_CLR_CODE   = 8'h03;
  localparam logic [1:0] SCAN_RESET      = 2'h1;
  // timing
  localparam logic [4:0] SCL_PER_SAMPLE  = 5'h12;  // 18 scl periods per sample
  localparam int CLK_NS          = 20;
  localparam int STRETCH_LOW_NS  = 1800;
  localparam int STD_PERIOD_NS   = 10000;          // 100 kHz standard mode
  localparam logic [SCL_W-1:0] STRETCH_CYC = SCL_W'((STRETCH_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [SCL_W-1:0] STD_PER_CYC = SCL_W'(STD_PERIOD_NS / CLK_NS);
  // host register byte addresses
  localparam logic [7:0] HREG_DEVCFG = 8'h00;  // device write: [11:8] index, [7:0] data
  localparam logic [7:0] HREG_DEVRD  = 8'h04;  // device read: [3:0] index
  localparam logic [7:0] HREG_CMD    = 8'h08;  // bit0 read frame, bit1 nack+stop
  localparam logic [7:0] HREG_SCL    = 8'h0C;  // [9:0] period, [25:16] low time
  localparam logic [7:0] HREG_DATA   = 8'h10;  // last sample {chan, data}
  localparam logic [7:0] HREG_STAT   = 8'h14;  // {count, reading, alert, reg data}
  localparam logic [SCL_W-1:0] SCL_PER_RST = 10'h032;
  localparam logic [SCL_W-1:0] SCL_LOW_RST = 10'h019;
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ARMED  = 2'b01,
    ST_MANUAL = 2'b10,
    ST_AUTO   = 2'b11
  } amsc_state_t;
endpackage : amsc_pkg

// [hw/amsc_link_if.sv]
// Purpose: link between the host controller and the sequencer device
// Assumes: both ends on clk_sys_i; scl abstracted to one tick per period
// Notes:   host holds ticks while stretch is high
`timescale 1ns/1ps
interface amsc_link_if
  import amsc_pkg::*;
();
  logic              cfg_we;       // register write pulse
  logic [3:0]        cfg_addr;     // register index
  logic [7:0]        cfg_wdata;    // register write data
  logic              reg_rd;       // register read pulse
  logic              rd_frame;     // address with read bit, pulse
  logic              nack_stop;    // nack then stop, pulse
  logic              scl_tick;     // one pulse per scl period
  logic [SCL_W-1:0]  scl_per_cyc;  // scl period in clocks
  logic [SCL_W-1:0]  scl_low_cyc;  // scl low time in clocks
  logic              stretch;      // device holds scl low
  logic              smp_valid;    // sample returned, pulse
  logic [DATA_W-1:0] smp_data;     // returned sample
  logic              smp_chan;     // channel of returned sample
  logic              reg_rvalid;   // register read answer, pulse
  logic [7:0]        reg_rdata;    // register read data
  logic              alert;        // alert level
  modport dev  (input cfg_we, cfg_addr, cfg_wdata, reg_rd, rd_frame, nack_stop, scl_tick,
                scl_per_cyc, scl_low_cyc,
                output stretch, smp_valid, smp_data, smp_chan, reg_rvalid, reg_rdata, alert);
  modport host (output cfg_we, cfg_addr, cfg_wdata, reg_rd, rd_frame, nack_stop, scl_tick,
                scl_per_cyc, scl_low_cyc,
                input stretch, smp_valid, smp_data, smp_chan, reg_rvalid, reg_rdata, alert);
endinterface : amsc_link_if

// [hw/amsc_device.sv]
// Purpose: mode and conversion sequence control of a two-input monitoring adc
// Assumes: converter answers conv_done_i before the next conv_start_o
// Notes:   internal oscillator is modelled as clk_sys_i
// Contract
// - reset into channel-0 manual, input zero first
// - manual paced by fast clock, divider ignored
// - manual capture per host command, returned over link
// - mode 000b or 001b is input_zero manual
// - read frame starts; clocking continues conversions
// - host ends with nack and stop
// - modes 100b/101b need go then read
// - host sets stop before changing mode
// - register read aborts manual auto sequence
// - one sample per eighteen scl periods
// - stretch short scl low by shortfall
// - scanned inputs alternate, input zero first
// - mode 110b is oscillator-paced autonomous
// - host go starts; device makes later starts
// - alert on enabled input threshold crossing
// - writing 03h clears latched flags
// - host should stop before reconfiguring
// - pre-alert policy stops on comparator flag
// - pre-alert buffer wraps over oldest entries
// - stop bit aborts storing in alert policies
// - post-alert stores sixteen after flag
// - start-burst fills sixteen then stops
// - stop-burst wraps until stop bit
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module amsc_device
  import amsc_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  // link to host
  amsc_link_if.dev               lnk,
  // converter
  output logic                   conv_start_o,
  output logic                   conv_chan_o,
  input  wire logic              conv_done_i,
  input  wire logic [DATA_W-1:0] conv_data_i,
  // buffer inspection and status
  input  wire logic [3:0]        buf_idx_i,
  output logic [DATA_W-1:0]      buf_data_o,
  output logic                   seq_active_o
);
  amsc_state_t       st_q, st_d;               // sequencer state
  logic [2:0]        mode_q;                   // operating_mode_select
  logic [1:0]        scan_q;                   // scan_channel_enable
  logic [2:0]        pol_q;                    // buffer_fill_policy
  logic [7:0]        div_q;                    // conversion_cycle_divider
  logic [1:0]        achen_q;                  // alert_channel_enable
  logic              wce_q;                    // window_compare_enable
  logic [7:0]        hi_th_q, lo_th_q;         // thresholds
  logic [1:0]        hi_flag_q, lo_flag_q;     // latched alert flags
  logic [4:0]        scl_cnt_q;                // scl periods inside a sample
  logic [SCL_W-1:0]  str_cnt_q;                // stretch cycles left
  logic [7:0]        osc_cnt_q;                // oscillator divider count
  logic              chan_q;                   // next input to convert
  logic [DATA_W-1:0] res_q;                    // latest result
  logic              res_chan_q;               // its input
  logic [DATA_W-1:0] buf_q [BUF_DEPTH];        // data buffer
  logic [3:0]        wptr_q;                   // buffer write pointer
  logic [4:0]        fill_q;                   // stored entries, saturating
  logic              trig_q;                   // post-alert capture armed
  logic              smp_valid_q, reg_rvalid_q;
  logic [DATA_W-1:0] smp_data_q;
  logic              smp_chan_q;
  logic [7:0]        reg_rdata_q;

  // write decode; go and stop are single-cycle pulses
  wire idle_w   = (st_q == ST_IDLE);
  wire wr_w     = lnk.cfg_we;
  wire wr_mode  = wr_w && (lnk.cfg_addr == REG_MODE) && idle_w;
  wire wr_pol   = wr_w && (lnk.cfg_addr == REG_POLICY) && idle_w;
  wire go_w     = wr_w && (lnk.cfg_addr == REG_GO) && lnk.cfg_wdata[0];
  wire stop_w   = wr_w && (lnk.cfg_addr == REG_STOP) && lnk.cfg_wdata[0];
  wire clr_hi_w = wr_w && (lnk.cfg_addr == REG_HI_FLAG) && (lnk.cfg_wdata == FLAG_CLR_CODE);
  wire clr_lo_w = wr_w && (lnk.cfg_addr == REG_LO_FLAG) && (lnk.cfg_wdata == FLAG_CLR_CODE);
  // mode classes
  wire is_ch0   = (mode_q == MODE_CH0_A) || (mode_q == MODE_CH0_B);
  wire is_seq   = (mode_q == MODE_SEQ_A) || (mode_q == MODE_SEQ_B);
  wire is_auto  = (mode_q == MODE_AUTO);
  wire both_w   = (scan_q == 2'b11);
  wire first_ch = (scan_q == 2'b10);   // only input one enabled
  // manual pacing: sample boundary every eighteen scl periods
  wire man_w    = (st_q == ST_MANUAL);
  wire tick_w   = man_w && lnk.scl_tick;
  wire frame0_w = tick_w && (scl_cnt_q == 5'h00);
  wire frameN_w = tick_w && (scl_cnt_q == SCL_PER_SAMPLE - 5'h01);
  // stretch only below 1.8 us low time and never in standard mode
  wire need_str = (lnk.scl_low_cyc < STRETCH_CYC) && (lnk.scl_per_cyc < STD_PER_CYC);
  // autonomous pacing from the divided oscillator
  wire auto_w   = (st_q == ST_AUTO);
  wire astart_w = auto_w && (osc_cnt_q == 8'h00);
  wire start_w  = frame0_w || astart_w;
  // comparator on the fresh result; enabled inputs only
  wire cmp_en   = auto_w && conv_done_i && wce_q && achen_q[conv_chan_o];
  wire hi_hit   = cmp_en && (conv_data_i[DATA_W-1:DATA_W-8] > hi_th_q);
  wire lo_hit   = cmp_en && (conv_data_i[DATA_W-1:DATA_W-8] < lo_th_q);
  wire [1:0] hi_set = hi_hit ? (2'b01 << conv_chan_o) : 2'b00;
  wire [1:0] lo_set = lo_hit ? (2'b01 << conv_chan_o) : 2'b00;
  wire flag_evt = hi_hit || lo_hit;
  // buffer storing by policy
  wire pol_post = (pol_q == POL_POST_ALERT);
  wire pol_pre  = (pol_q == POL_PRE_ALERT);
  wire pol_cnt  = (pol_q == POL_START_BURST) || pol_post;
  wire store_w  = auto_w && conv_done_i && (!pol_post || trig_q);
  wire full_w   = store_w && pol_cnt && (fill_q == 5'(BUF_DEPTH - 1));
  wire pre_end  = pol_pre && flag_evt;
  wire auto_end = full_w || pre_end || stop_w;

  // next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (is_ch0 && lnk.rd_frame) st_d = ST_MANUAL;
        else if (is_seq && go_w) st_d = ST_ARMED;
        else if (is_auto && go_w) st_d = ST_AUTO;
      end
      ST_ARMED: begin
        if (stop_w || lnk.reg_rd) st_d = ST_IDLE;
        else if (lnk.rd_frame) st_d = ST_MANUAL;
      end
      ST_MANUAL: begin
        if (is_ch0 && lnk.nack_stop) st_d = ST_IDLE;
        else if (is_seq && (stop_w || lnk.reg_rd)) st_d = ST_IDLE;
        else if (is_seq && lnk.nack_stop) st_d = ST_ARMED;
      end
      ST_AUTO: begin
        if (auto_end) st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // state and configuration; power-up is channel-0 manual
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q    <= ST_IDLE;
      mode_q  <= MODE_CH0_A;
      scan_q  <= SCAN_RESET;
      pol_q   <= POL_STOP_BURST;
      div_q   <= 8'h00;
      achen_q <= 2'h0;
      wce_q   <= 1'b0;
      hi_th_q <= 8'hFF;
      lo_th_q <= 8'h00;
    end else begin
      st_q <= st_d;
      if (wr_mode) mode_q <= lnk.cfg_wdata[2:0];
      if (wr_pol) pol_q <= lnk.cfg_wdata[2:0];
      if (wr_w && (lnk.cfg_addr == REG_SCAN)) scan_q <= lnk.cfg_wdata[1:0];
      if (wr_w && (lnk.cfg_addr == REG_DIV)) div_q <= lnk.cfg_wdata;
      if (wr_w && (lnk.cfg_addr == REG_ACHEN)) achen_q <= lnk.cfg_wdata[1:0];
      if (wr_w && (lnk.cfg_addr == REG_ACTL)) wce_q <= lnk.cfg_wdata[0];
      if (wr_w && (lnk.cfg_addr == REG_HI_TH)) hi_th_q <= lnk.cfg_wdata;
      if (wr_w && (lnk.cfg_addr == REG_LO_TH)) lo_th_q <= lnk.cfg_wdata;
    end
  end

  // sticky flags; a crossing in the clearing cycle survives
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hi_flag_q <= 2'h0;
      lo_flag_q <= 2'h0;
    end else begin
      hi_flag_q <= (clr_hi_w ? 2'h0 : hi_flag_q) | hi_set;
      lo_flag_q <= (clr_lo_w ? 2'h0 : lo_flag_q) | lo_set;
    end
  end

  // manual scl counting and clock stretch
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_cnt_q <= 5'h00;
      str_cnt_q <= '0;
    end else begin
      if (!man_w || frameN_w) scl_cnt_q <= 5'h00;
      else if (tick_w) scl_cnt_q <= scl_cnt_q + 5'h01;
      if (tick_w && need_str) str_cnt_q <= STRETCH_CYC - lnk.scl_low_cyc;
      else if (!man_w) str_cnt_q <= '0;
      else if (str_cnt_q != '0) str_cnt_q <= str_cnt_q - 1'b1;
    end
  end

  // oscillator divider: only autonomous uses it, manual ignores it
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) osc_cnt_q <= 8'h00;
    else if (!auto_w || osc_cnt_q == div_q) osc_cnt_q <= 8'h00;
    else osc_cnt_q <= osc_cnt_q + 8'h01;
  end

  // conversion start and input alternation
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv_start_o <= 1'b0;
      conv_chan_o  <= 1'b0;
      chan_q       <= 1'b0;
    end else begin
      conv_start_o <= start_w;
      if (start_w) conv_chan_o <= is_ch0 ? 1'b0 : chan_q;
      if (idle_w) chan_q <= first_ch;
      else if (start_w && both_w) chan_q <= ~chan_q;
    end
  end

  // result capture and return to host at the sample boundary
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      res_q       <= '0;
      res_chan_q  <= 1'b0;
      smp_valid_q <= 1'b0;
      smp_data_q  <= '0;
      smp_chan_q  <= 1'b0;
    end else begin
      if (conv_done_i) res_q <= conv_data_i;
      if (conv_done_i) res_chan_q <= conv_chan_o;
      smp_valid_q <= frameN_w;
      if (frameN_w) smp_data_q <= res_q;
      if (frameN_w) smp_chan_q <= res_chan_q;
    end
  end

  // data buffer; pointer wraps so oldest entries are overwritten
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wptr_q <= 4'h0;
      fill_q <= 5'h00;
      trig_q <= 1'b0;
    end else if (idle_w && go_w) begin
      wptr_q <= 4'h0;
      fill_q <= 5'h00;
      trig_q <= 1'b0;
    end else begin
      if (store_w) wptr_q <= wptr_q + 4'h1;
      if (store_w && fill_q != 5'(BUF_DEPTH)) fill_q <= fill_q + 5'h01;
      // arming on the crossing itself keeps the alerting sample out
      if (auto_w && pol_post && flag_evt) trig_q <= 1'b1;
    end
  end

  // buffer storage; no reset needed on data
  always_ff @(posedge clk_sys_i) begin
    if (store_w) buf_q[wptr_q] <= conv_data_i;
    buf_data_o <= buf_q[buf_idx_i];
  end

  // register read answer, one cycle after the request
  wire [7:0] rsel_w =
    (lnk.cfg_addr == REG_MODE)    ? {5'h00, mode_q} :
    (lnk.cfg_addr == REG_POLICY)  ? {5'h00, pol_q} :
    (lnk.cfg_addr == REG_HI_FLAG) ? {6'h00, hi_flag_q} :
    (lnk.cfg_addr == REG_LO_FLAG) ? {6'h00, lo_flag_q} :
    (lnk.cfg_addr == REG_STATUS)  ? {1'b0, fill_q, st_q} : 8'h00;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rvalid_q <= 1'b0;
      reg_rdata_q  <= 8'h00;
    end else begin
      reg_rvalid_q <= lnk.reg_rd;
      if (lnk.reg_rd) reg_rdata_q <= rsel_w;
    end
  end

  // link outputs
  assign lnk.stretch    = man_w && (str_cnt_q != '0);
  assign lnk.smp_valid  = smp_valid_q;
  assign lnk.smp_data   = smp_data_q;
  assign lnk.smp_chan   = smp_chan_q;
  assign lnk.reg_rvalid = reg_rvalid_q;
  assign lnk.reg_rdata  = reg_rdata_q;
  assign lnk.alert      = |{hi_flag_q, lo_flag_q};
  assign seq_active_o   = !idle_w;
endmodule : amsc_device

// [hw/amsc_host.sv]
// Purpose: host-side controller driving the sequencer link from a register port
// Assumes: software follows the stop-before-reconfigure order
// Notes:   scl ticks pause while the device stretches
`timescale 1ns/1ps
module amsc_host
  import amsc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // software register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  // link to device
  amsc_link_if.host        lnk
);
  logic              cfg_we_q, reg_rd_q, frame_q, nack_q;  // link pulses
  logic [3:0]        cfg_addr_q;
  logic [7:0]        cfg_wdata_q;
  logic              reading_q;                            // read frame open
  logic [SCL_W-1:0]  per_q, low_q, scl_cnt_q;              // scl timing
  logic [DATA_W-1:0] last_q;                               // last sample
  logic              last_chan_q;
  logic [15:0]       smp_cnt_q;                            // samples received
  logic [7:0]        rreg_q;                               // last device register

  // address decode
  wire hit_cfg = (addr_i == HREG_DEVCFG);
  wire hit_drd = (addr_i == HREG_DEVRD);
  wire hit_cmd = (addr_i == HREG_CMD);
  wire hit_scl = (addr_i == HREG_SCL);
  wire tick_w  = reading_q && !lnk.stretch && (scl_cnt_q == per_q - 1'b1);
  wire [31:0] rsel_w =
    hit_scl ? {6'h00, low_q, 6'h00, per_q} :
    (addr_i == HREG_DATA) ? {19'h0_0000, last_chan_q, last_q} :
    (addr_i == HREG_STAT) ? {smp_cnt_q, 6'h00, reading_q, lnk.alert, rreg_q} : 32'h0000_0000;

  // command pulses toward the device
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_we_q    <= 1'b0;
      reg_rd_q    <= 1'b0;
      frame_q     <= 1'b0;
      nack_q      <= 1'b0;
      cfg_addr_q  <= 4'h0;
      cfg_wdata_q <= 8'h00;
    end else begin
      cfg_we_q <= wr_i && hit_cfg;
      reg_rd_q <= wr_i && hit_drd;
      frame_q  <= wr_i && hit_cmd && wdata_i[0];
      nack_q   <= wr_i && hit_cmd && wdata_i[1];
      if (wr_i && hit_cfg) cfg_addr_q <= wdata_i[11:8];
      else if (wr_i && hit_drd) cfg_addr_q <= wdata_i[3:0];
      if (wr_i && hit_cfg) cfg_wdata_q <= wdata_i[7:0];
    end
  end

  // scl generation keeps running while a frame is open
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reading_q <= 1'b0;
      per_q     <= SCL_PER_RST;
      low_q     <= SCL_LOW_RST;
      scl_cnt_q <= '0;
    end else begin
      if (wr_i && hit_cmd && wdata_i[1]) reading_q <= 1'b0;
      else if (wr_i && hit_cmd && wdata_i[0]) reading_q <= 1'b1;
      if (wr_i && hit_scl) per_q <= wdata_i[9:0];
      if (wr_i && hit_scl) low_q <= wdata_i[25:16];
      if (!reading_q || tick_w) scl_cnt_q <= '0;
      else if (!lnk.stretch) scl_cnt_q <= scl_cnt_q + 1'b1;
    end
  end

  // collect returned data and answer software reads
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_q      <= '0;
      last_chan_q <= 1'b0;
      smp_cnt_q   <= 16'h0000;
      rreg_q      <= 8'h00;
      rdata_o     <= 32'h0000_0000;
    end else begin
      if (lnk.smp_valid) last_q <= lnk.smp_data;
      if (lnk.smp_valid) last_chan_q <= lnk.smp_chan;
      if (lnk.smp_valid) smp_cnt_q <= smp_cnt_q + 16'h0001;
      if (lnk.reg_rvalid) rreg_q <= lnk.reg_rdata;
      rdata_o <= rd_i ? rsel_w : 32'h0000_0000;
    end
  end

  // link outputs
  assign lnk.cfg_we      = cfg_we_q;
  assign lnk.cfg_addr    = cfg_addr_q;
  assign lnk.cfg_wdata   = cfg_wdata_q;
  assign lnk.reg_rd      = reg_rd_q;
  assign lnk.rd_frame    = frame_q;
  assign lnk.nack_stop   = nack_q;
  assign lnk.scl_tick    = tick_w;
  assign lnk.scl_per_cyc = per_q;
  assign lnk.scl_low_cyc = low_q;
endmodule : amsc_host

// [dv/amsc_link_sva.sv]
// Purpose: link timing checks between host and sequencer
// Assumes: one clock, reset async and active low
// Notes:   sees link signals only, so device internals stay untested here
`timescale 1ns/1ps
module amsc_link_sva
  import amsc_pkg::*;
(
  // link signals, all on clk_sys_i
  input wire logic             clk_sys_i, rst_n_i, reg_rd, reg_rvalid,
  input wire logic             scl_tick, stretch, smp_valid, alert,
  input wire logic [SCL_W-1:0] scl_low_cyc
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic [4:0] tick_n_q; // ticks since last sample, saturates
  // count ticks so sample spacing can be judged
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) tick_n_q <= 5'h00;
    else if (smp_valid) tick_n_q <= {4'h0, scl_tick};
    else if (scl_tick && tick_n_q != 5'h1f) tick_n_q <= tick_n_q + 5'h01;
  end
  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("register read got no answer");
  rd_source_a: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("register answer without a read");
  smp_pulse_a: assert property (smp_valid |=> !smp_valid)
    else $error("sample strobe longer than one cycle");
  smp_tick_a: assert property (smp_valid |-> $past(scl_tick))
    else $error("sample not right after an scl tick");
  smp_count_a: assert property (smp_valid |-> tick_n_q >= SCL_PER_SAMPLE)
    else $error("sample after too few scl ticks");
  stretch_low_a: assert property (stretch |-> scl_low_cyc < STRETCH_CYC)
    else $error("stretch with a long scl low time");
  tick_hold_a: assert property (stretch |-> !scl_tick)
    else $error("scl tick while stretched");
  stretch_end_a: assert property ($rose(stretch) |-> ##[1:90] !stretch)
    else $error("stretch longer than the low shortfall");
  cover property (smp_valid);
  cover property ($rose(stretch));
  cover property ($rose(alert));
  cover property (reg_rvalid);
endmodule : amsc_link_sva

// [dv/adc_mode_sequencer_control_tb.sv]
// Purpose: host and sequencer joined, driven from the software port
// Assumes: converter answers one cycle after each start
// Notes:   samples are found by polling the host sample count
`timescale 1ns/1ps
module adc_mode_sequencer_control_tb;
  import amsc_pkg::*;
  logic              clk_sys_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, conv_done_i = 0;
  logic [7:0]        addr_i = '0;
  logic [31:0]       wdata_i = '0, rdata_o, rv;
  logic [DATA_W-1:0] conv_data_i = '0, buf_data_o, base = '0;
  logic [3:0]        buf_idx_i = '0;
  logic              conv_start_o, conv_chan_o, seq_active_o;
  int                err_total = 0, checks = 0, ncv = 0;
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_total++; $display("Error %s exp %h got %h", n, e, s); end end
  amsc_link_if lnk ();
  amsc_host i_amsc_host (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .lnk(lnk));
  amsc_device i_amsc_device (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .lnk(lnk), .conv_start_o(conv_start_o),
    .conv_chan_o(conv_chan_o), .conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .buf_idx_i(buf_idx_i),
    .buf_data_o(buf_data_o), .seq_active_o(seq_active_o));
  amsc_link_sva i_amsc_link_sva (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_rd(lnk.reg_rd),
    .reg_rvalid(lnk.reg_rvalid), .scl_tick(lnk.scl_tick), .stretch(lnk.stretch), .smp_valid(lnk.smp_valid),
    .alert(lnk.alert), .scl_low_cyc(lnk.scl_low_cyc));
  // clock at 50 MHz
  initial forever #10 clk_sys_i = ~clk_sys_i;
  // converter model: result steps by one per conversion
  always @(posedge clk_sys_i) begin
    conv_done_i <= conv_start_o;
    if (conv_start_o) begin conv_data_i <= base + 12'(ncv); ncv++; end
  end
  // software port write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i); addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
    @(posedge clk_sys_i); wr_i <= 1'b0;
  endtask : wr
  // software port read, data taken in the following cycle
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_i); addr_i <= a; rd_i <= 1'b1;
    @(posedge clk_sys_i); rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask : rd
  // device register write and read through the host
  task automatic dw(input logic [3:0] x, input logic [7:0] d); wr(HREG_DEVCFG, {20'h0_0000, x, d}); endtask : dw
  task automatic dr(input logic [3:0] x);
    wr(HREG_DEVRD, {28'h000_0000, x}); repeat (4) @(posedge clk_sys_i); rd(HREG_STAT);
  endtask : dr
  // wait for the next returned sample, then fetch it
  task automatic nxt();
    logic [15:0] c;
    rd(HREG_STAT); c = rv[31:16];
    for (int i = 0; i < 1500 && rv[31:16] == c; i++) rd(HREG_STAT);
    rd(HREG_DATA);
  endtask : nxt
  // wait while a sequence runs, bounded
  task automatic idle_wait();
    repeat (3) @(posedge clk_sys_i);
    for (int k = 0; k < 2000 && seq_active_o !== 1'b0; k++) @(posedge clk_sys_i);
  endtask : idle_wait
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  // hang guard, well past the expected run length
  initial begin #1_800_000; err_total++; tally_and_finish(); end
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    dr(REG_MODE); `CHK("reset mode", MODE_CH0_A, rv[2:0])
    // both channel-zero codes; second pass with a long scl low time
    for (int m = 0; m < 2; m++) begin
      if (m == 1) wr(HREG_SCL, {6'h00, 10'h064, 6'h00, 10'h096});
      dw(REG_MODE, {5'h00, m[0] ? MODE_CH0_B : MODE_CH0_A}); ncv = 0; base = 12'h123;
      wr(HREG_CMD, 32'h0000_0001);
      nxt(); `CHK("ch0 first", {1'b0, base}, rv[12:0])
      nxt(); `CHK("ch0 next", {1'b0, base + 12'h001}, rv[12:0])
      wr(HREG_CMD, 32'h0000_0002);
    end
    // scanned manual sequence, both codes, ended by a register read
    dw(REG_SCAN, 8'h03);
    for (int m = 0; m < 2; m++) begin
      dw(REG_MODE, {5'h00, m[0] ? MODE_SEQ_B : MODE_SEQ_A}); dw(REG_GO, 8'h01); wr(HREG_CMD, 32'h0000_0001);
      for (int i = 0; i < 3; i++) begin nxt(); `CHK("scan input", i[0], rv[12]) end
      dr(REG_STATUS); dr(REG_STATUS); `CHK("read abort", ST_IDLE, rv[1:0])
      wr(HREG_CMD, 32'h0000_0002); dw(REG_STOP, 8'h01);
    end
    // autonomous start burst fills sixteen entries then stops
    dw(REG_MODE, {5'h00, MODE_AUTO}); dw(REG_POLICY, {5'h00, POL_START_BURST}); dw(REG_DIV, 8'h03);
    ncv = 0; base = 12'h200; dw(REG_GO, 8'h01); idle_wait();
    dr(REG_STATUS); `CHK("burst status", 8'h40, rv[7:0])
    for (int i = 0; i < 16; i++) begin
      buf_idx_i <= 4'(i); repeat (2) @(posedge clk_sys_i);
      `CHK("burst entry", base + 12'(i), buf_data_o)
    end
    // pre-alert: threshold crossed on the 21st conversion, buffer wrapped
    dw(REG_POLICY, {5'h00, POL_PRE_ALERT}); dw(REG_ACHEN, 8'h03); dw(REG_ACTL, 8'h01); dw(REG_HI_TH, 8'h80);
    ncv = 0; base = 12'h7fc; dw(REG_GO, 8'h01); idle_wait();
    dr(REG_STATUS); `CHK("pre-alert stop", 8'h40, rv[7:0])
    buf_idx_i <= 4'h4; repeat (2) @(posedge clk_sys_i);
    `CHK("wrapped entry", 12'h810, buf_data_o)
    rd(HREG_STAT); `CHK("alert set", 1'b1, rv[8])
    dw(REG_HI_FLAG, 8'h02); rd(HREG_STAT); `CHK("alert kept", 1'b1, rv[8])
    dw(REG_HI_FLAG, FLAG_CLR_CODE); rd(HREG_STAT); `CHK("alert cleared", 1'b0, rv[8])
    // post-alert: crossing on the fifth conversion, the next sixteen kept
    dw(REG_POLICY, {5'h00, POL_POST_ALERT}); ncv = 0; base = 12'h80c; dw(REG_GO, 8'h01); idle_wait();
    buf_idx_i <= 4'h0; repeat (2) @(posedge clk_sys_i);
    `CHK("post-alert entry", 12'h811, buf_data_o)
    // stop-burst wraps until stopped; a mode write while running is refused
    dw(REG_POLICY, {5'h00, POL_STOP_BURST}); base = 12'h000; dw(REG_GO, 8'h01);
    dw(REG_MODE, {5'h00, MODE_CH0_A}); repeat (100) @(posedge clk_sys_i);
    dw(REG_STOP, 8'h01); idle_wait();
    dr(REG_STATUS); `CHK("stop-burst wrap", 8'h40, rv[7:0])
    dr(REG_MODE); `CHK("mode held", MODE_AUTO, rv[2:0])
    tally_and_finish();
  end
endmodule : adc_mode_sequencer_control_tb
